/* rsf_cfg.svh */
// Purpose: Constants for the reset source filter and status block
// Assumes: 40 MHz bus clock, slow oscillator tick arrives as a pulse
// Notes:   Header of definitions only
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH
// ==========================================================
// Timing
`define RSF_CLK_MHZ          40
`define RSF_LPO_FIX_COUNT    3
`define RSF_SYNC_STAGES      2
`define RSF_PIN_HOLD_CYC     128
`define RSF_SACK_LIMIT_LPO   1025
// ==========================================================
// Cause flag positions
`define RSF_BIT_POR          0
`define RSF_BIT_LVD          1
`define RSF_BIT_PIN          2
`define RSF_BIT_SACK         3
`define RSF_BIT_OTHER        4
`define RSF_BIT_JTAG         5
`define RSF_CAUSE_W          6
`define RSF_CAUSE_RST        6'h00
// ==========================================================
// Boot values
`define RSF_SP_OFFSET        32'h0000_0000
`define RSF_PC_OFFSET        32'h0000_0004
`define RSF_LR_RESET         32'hFFFF_FFFF
`endif

/* rsf_far_model.sv */
// Purpose: Far side of the reset block: open-drain pin and slow tick
// Assumes: Slow tick is a one-cycle pulse every TICK_DIV bus cycles
// Notes:   Behavioural; the supply monitor level comes from the bench
`timescale 1ns/1ps
`default_nettype none
module rsf_far_model #(
	parameter int TICK_DIV = 8
) (
	// Clock
	input  wire logic clock_in,
	// Pin drivers
	input  wire logic ext_low_in,
	input  wire logic dev_drive_in,
	input  wire logic dev_oe_in,
	// Pin level and slow tick
	output logic      pin_level_out,
	output logic      tick_out
);
	// ==========================================================
	// Pin wire and slow oscillator
	int unsigned div_count = 0; // Tick divider, shortened for run time
	// Any low driver wins, otherwise the pull-up holds the pin high
	assign pin_level_out = (ext_low_in || (dev_oe_in && !dev_drive_in)) ? 1'b0 : 1'b1;
	// Tick runs free, the slow clock never stops in the modes used here
	assign tick_out = (div_count == TICK_DIV - 1);
	// Divider wraps so ticks stay evenly spaced
	always_ff @(posedge clock_in) begin
		div_count <= (div_count == TICK_DIV - 1) ? 0 : div_count + 1;
	end
endmodule // rsf_far_model
`default_nettype wire

/* rsf_pkg.sv */
// Purpose: Types for the reset source filter and status block
// Assumes: Constants come from rsf_cfg.svh
// Notes:   Types only
package rsf_pkg;
	// ======================================================
	// Power modes
	typedef enum logic [6:0] {
		RSF_MODE_RUN    = 7'b000_0001,
		RSF_MODE_HSRUN  = 7'b000_0010,
		RSF_MODE_WAIT   = 7'b000_0100,
		RSF_MODE_STOP   = 7'b000_1000,
		RSF_MODE_VLP    = 7'b001_0000,
		RSF_MODE_LLS    = 7'b010_0000,
		RSF_MODE_DEEPEST_LEAKAGE_STOP_MODE  = 7'b100_0000
	} rsf_mode_e;
	// Sequencer states
	typedef enum logic [2:0] {
		RSF_ST_HOLD = 3'b001,
		RSF_ST_WAIT = 3'b010,
		RSF_ST_RUN  = 3'b100
	} rsf_state_e;
	// Filter configuration group
	typedef struct packed {
		logic [1:0] run_wait_filter_select;
		logic [1:0] stop_filter_select;
		logic [4:0] filter_width_select;
	} rsf_filt_cfg_s;
	// Boot fetch group
	typedef struct packed {
		logic        valid;
		logic [31:0] sp_addr;
		logic [31:0] pc_addr;
		logic [31:0] link_reg;
	} rsf_boot_s;
endpackage

/* rsf_tb.sv */
// Purpose: Self-checking bench for the reset filter and cause flags
// Assumes: Short counts HOLD_CYC=8, SACK_LIMIT=4, tick every 8 cycles
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ==========================================================
	// Signals
	localparam int HOLD = 8; // Shortened pin hold count
	logic clock_in, rst_in, ext_low, pin_lvl, pin_drv, pin_oe, tick;
	logic supply_low, lv_en, oth_req, jtag_req, stop_req, stop_ack, flash_done;
	logic lv_det_en, chip_rst, periph_en, reg_full, int_clk, tck_pd;
	logic [1:0] lv_sel, lv_thr;
	logic [5:0] flags;
	logic [3:0] pulls;
	rsf_pkg::rsf_mode_e mode;
	rsf_pkg::rsf_filt_cfg_s cfg;
	rsf_pkg::rsf_boot_s boot;
	int bad_count = 0;
	int samples_checked = 0;
	// ==========================================================
	// Design and far side
	rsf_top #(.SACK_LIMIT(4), .HOLD_CYC(HOLD)) dut_u (.clock_in(clock_in), .rst_in(rst_in),
		.reset_pin_in(pin_lvl), .reset_pin_out(pin_drv), .reset_pin_oe_out(pin_oe),
		.low_power_osc_clock_in(tick), .mode_in(mode), .filt_cfg_in(cfg),
		.supply_low_in(supply_low), .lowvolt_reset_enable_in(lv_en),
		.lowvolt_threshold_select_in(lv_sel), .other_reset_req_in(oth_req),
		.jtag_reset_req_in(jtag_req), .stop_req_in(stop_req), .stop_ack_in(stop_ack),
		.flash_init_done_in(flash_done), .reset_cause_flags_out(flags),
		.lowvolt_threshold_out(lv_thr), .lowvolt_detect_enable_out(lv_det_en),
		.chip_reset_out(chip_rst), .periph_enable_out(periph_en),
		.regulator_full_out(reg_full), .internal_clock_sel_out(int_clk),
		.test_pin_pull_up_out(pulls), .tck_pull_down_out(tck_pd), .boot_out(boot));
	rsf_far_model #(.TICK_DIV(8)) far_u (.clock_in(clock_in), .ext_low_in(ext_low),
		.dev_drive_in(pin_drv), .dev_oe_in(pin_oe), .pin_level_out(pin_lvl),
		.tick_out(tick));
	// ==========================================================
	// Tasks
	// Compare one value, wide enough for every result here
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Step n edges, then land just after the last one
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// Bounded wait for chip reset to reach a level
	task automatic wait_rst(input logic lvl, input int lim);
		int i;
		for (i = 0; i < lim && chip_rst !== lvl; i++) cyc(1);
		chk(32'(chip_rst), 32'(lvl));
	endtask
	// Verdict, the single end of the run
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ==========================================================
	// Clock and watchdog
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	// The tests need under two thousand cycles; this leaves wide margin
	initial begin
		#(25 * 20000);
		bad_count++;
		summarize();
	end
	// ==========================================================
	// Main sequence
	initial begin
		int n;
		rst_in = 1'b1;
		ext_low = 1'b0;
		mode = rsf_pkg::RSF_MODE_RUN;
		cfg = '{2'h2, 2'h2, 5'h04};
		{supply_low, oth_req, jtag_req, stop_req, stop_ack} = 5'h00;
		{lv_en, flash_done} = 2'h3;
		lv_sel = 2'h2;
		cyc(12);
		chk(32'(pin_oe), 32'h0000_0001);
		rst_in = 1'b0;
		cyc(1);
		chk(32'(flags), 32'h0000_0003);
		wait_rst(1'b0, 400);
		chk(boot.sp_addr, 32'h0000_0000);
		chk(boot.pc_addr, 32'h0000_0004);
		chk(boot.link_reg, 32'hFFFF_FFFF);
		chk(32'({pulls, tck_pd}), 32'h0000_0007);
		chk(32'({periph_en, reg_full, int_clk}), 32'h0000_0003);
		chk(32'(lv_thr), 32'h0000_0002);
		// Detector enable across every power mode
		for (int m = 0; m < 7; m++) begin
			mode = rsf_pkg::rsf_mode_e'(7'h01 << m);
			cyc(3);
			chk(32'(lv_det_en), 32'(m < 4));
		end
		// Low supply in a low-power mode must not reset
		mode = rsf_pkg::RSF_MODE_VLP;
		supply_low = 1'b1;
		cyc(60);
		chk(32'(chip_rst), 32'h0000_0000);
		supply_low = 1'b0;
		mode = rsf_pkg::RSF_MODE_RUN;
		cyc(3);
		// Low-voltage reset held while the supply stays low
		supply_low = 1'b1;
		wait_rst(1'b1, 20);
		cyc(100);
		chk(32'(chip_rst), 32'h0000_0001);
		supply_low = 1'b0;
		wait_rst(1'b0, 400);
		chk(32'(flags), 32'h0000_0002);
		lv_en = 1'b0;
		supply_low = 1'b1;
		cyc(60);
		chk(32'(chip_rst), 32'h0000_0000);
		{supply_low, lv_en} = 2'h1;
		// Two slow ticks at most: the slow filter must reject it
		ext_low = 1'b1;
		cyc(12);
		ext_low = 1'b0;
		cyc(80);
		chk(32'(chip_rst), 32'h0000_0000);
		chk(32'(flags), 32'h0000_0002);
		// Long pin assertion through slow, bus and bypass paths
		for (int s = 0; s < 3; s++) begin
			cfg.run_wait_filter_select = 2'(2 - s);
			ext_low = 1'b1;
			cyc(60);
			chk(32'(chip_rst), 32'h0000_0001);
			ext_low = 1'b0;
			wait_rst(1'b0, 400);
			chk(32'(flags), 32'h0000_0004);
		end
		// Deepest stop bypasses the filter, so a short pulse resets
		cfg.run_wait_filter_select = 2'h2;
		mode = rsf_pkg::RSF_MODE_DEEPEST_LEAKAGE_STOP_MODE;
		ext_low = 1'b1;
		cyc(6);
		ext_low = 1'b0;
		wait_rst(1'b1, 20);
		mode = rsf_pkg::RSF_MODE_RUN;
		wait_rst(1'b0, 400);
		// Pin stays driven until flash init is done
		flash_done = 1'b0;
		oth_req = 1'b1;
		wait_rst(1'b1, 20);
		oth_req = 1'b0;
		cyc(HOLD + 20);
		chk(32'(pin_oe), 32'h0000_0001);
		flash_done = 1'b1;
		wait_rst(1'b0, 400);
		chk(32'(flags), 32'h0000_0010);
		// Minimum drive time with flash already done
		oth_req = 1'b1;
		wait_rst(1'b1, 20);
		oth_req = 1'b0;
		for (n = 0; n < 1000 && pin_oe === 1'b1; n++) cyc(1);
		chk(32'(n >= HOLD), 32'h0000_0001);
		wait_rst(1'b0, 400);
		// Debug reset only marks its flag
		jtag_req = 1'b1;
		cyc(30);
		chk(32'(chip_rst), 32'h0000_0000);
		chk(32'(flags[5]), 32'h0000_0001);
		jtag_req = 1'b0;
		// Stop entry: acknowledged is fine, missing ack resets
		{stop_req, stop_ack} = 2'h3;
		cyc(100);
		chk(32'(chip_rst), 32'h0000_0000);
		stop_ack = 1'b0;
		wait_rst(1'b1, 200);
		stop_req = 1'b0;
		wait_rst(1'b0, 400);
		chk(32'(flags), 32'h0000_0008);
		// Second power-on reset in mid-run
		rst_in = 1'b1;
		cyc(2);
		chk(32'(pin_oe), 32'h0000_0001);
		rst_in = 1'b0;
		cyc(1);
		chk(32'(flags), 32'h0000_0003);
		wait_rst(1'b0, 400);
		summarize();
	end
endmodule // tb
`default_nettype wire

/* rsf_top.sv */
// Purpose: Reset pin filter, reset cause flags and reset sequencing
// Assumes: Slow oscillator tick is a one-cycle pulse in clock_in domain
// Notes:   Chip power-on reset is rst_in; flags survive other resets
//
// Operation
// R1: Pin filter runs from slow tick or bus
// R2: Power-on clears filters to negated state
// R3: Stop modes use slow filter or bypass
// R4: Deepest leakage stop bypasses the filter
// R5: Slow filter count three after two-stage sync
// R6: Open-drain pin wakes device, sets pin flag
// R7: Each reset source owns one cause flag
// R8: Power-on sets power-on and low-voltage flags
// R9: Low-voltage resets only when enable set
// R10: Low-voltage reset held while supply low
// R11: Low-voltage flag set after low-voltage reset
// R12: Detector active only in run, wait, stop; code also enables it in high-speed run
// R13: Boot fetch SP at 0, PC at 4
// R14: Peripherals and digital pins start disabled
// R15: Test pins get their reset pulls
// R16: Reset starts in full regulation, internal clock
// R17: Leave reset running; debug resets kept apart
// R18: Drive pin low 128 cycles and flash done
// R19: Stop ack timeout raises its own reset
// R20: Pin flag set only from filtered input
`include "rsf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rsf_top #(
	parameter int SACK_LIMIT = `RSF_SACK_LIMIT_LPO,
	parameter int HOLD_CYC   = `RSF_PIN_HOLD_CYC
) (
	// Clock and chip power-on reset
	input  wire logic                  clock_in,
	input  wire logic                  rst_in,
	// Reset pin, open drain
	input  wire logic                  reset_pin_in,
	output logic                       reset_pin_out,
	output logic                       reset_pin_oe_out,
	// Slow oscillator tick and mode
	input  wire logic                  low_power_osc_clock_in,
	input  wire rsf_pkg::rsf_mode_e    mode_in,
	input  wire rsf_pkg::rsf_filt_cfg_s filt_cfg_in,
	// Supply monitor
	input  wire logic                  supply_low_in,
	input  wire logic                  lowvolt_reset_enable_in,
	input  wire logic [1:0]            lowvolt_threshold_select_in,
	// Other system reset requests, debug reset, stop handshake
	input  wire logic                  other_reset_req_in,
	input  wire logic                  jtag_reset_req_in,
	input  wire logic                  stop_req_in,
	input  wire logic                  stop_ack_in,
	input  wire logic                  flash_init_done_in,
	// Status and control outputs
	output logic [`RSF_CAUSE_W-1:0]    reset_cause_flags_out,
	output logic [1:0]                 lowvolt_threshold_out,
	output logic                       lowvolt_detect_enable_out,
	output logic                       chip_reset_out,
	output logic                       periph_enable_out,
	output logic                       regulator_full_out,
	output logic                       internal_clock_sel_out,
	output logic [3:0]                 test_pin_pull_up_out,
	output logic                       tck_pull_down_out,
	output rsf_pkg::rsf_boot_s         boot_out
);
	// ======================================================
	// Input synchronisers
	logic [1:0] pin_sync;    // Raw pin, two stages
	logic [1:0] sup_sync;    // Supply monitor, two stages
	logic       pin_s;       // Synchronised pin (low = asserted)
	logic       sup_s;       // Synchronised supply low

	// Two flops per asynchronous input; only the last stage is read [R2]
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pin_sync <= 2'b11;
			sup_sync <= 2'b00;
		end else begin
			pin_sync <= {pin_sync[0], reset_pin_in};
			sup_sync <= {sup_sync[0], supply_low_in};
		end
	end
	assign pin_s = pin_sync[1];
	assign sup_s = sup_sync[1];

	// ======================================================
	// Pin filter
	logic       deep_stop;   // Deepest leakage stop active
	logic       in_stop;     // Any stop mode with slow clock alive
	logic       use_slow;    // Slow filter chosen
	logic       use_bus;     // Bus filter chosen
	logic [4:0] flt_cnt;     // Agreement counter
	logic [4:0] flt_lim;     // Count that makes a change stick
	logic       flt_out;     // Filtered pin level
	logic       pin_eff;     // Pin level seen by the reset logic

	assign deep_stop = (mode_in == rsf_pkg::RSF_MODE_DEEPEST_LEAKAGE_STOP_MODE);
	assign in_stop   = (mode_in == rsf_pkg::RSF_MODE_STOP) || (mode_in == rsf_pkg::RSF_MODE_LLS);
	// Bus clock dies in stop, so only the slow filter may remain [R1] [R3]
	assign use_slow  = in_stop ? filt_cfg_in.stop_filter_select == 2'b10
	                           : filt_cfg_in.run_wait_filter_select == 2'b10;
	assign use_bus   = !in_stop && filt_cfg_in.run_wait_filter_select == 2'b01;
	// Slow filter has a fixed count of three on top of the two sync stages [R5]
	assign flt_lim   = use_slow ? 5'(`RSF_LPO_FIX_COUNT - 1) : filt_cfg_in.filter_width_select;

	// Counter advances on the chosen clock while input differs [R1] [R5]
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			flt_cnt <= 5'h0_0;
			flt_out <= 1'b1;         // Negated after power-on [R2]
		end else if (!(use_slow || use_bus) || deep_stop) begin
			flt_cnt <= 5'h0_0;
			flt_out <= pin_s;        // Bypass [R3] [R4]
		end else if (pin_s == flt_out) begin
			flt_cnt <= 5'h0_0;
		end else if (use_bus || low_power_osc_clock_in) begin
			if (flt_cnt >= flt_lim) begin
				flt_out <= pin_s;
				flt_cnt <= 5'h0_0;
			end else begin
				flt_cnt <= flt_cnt + 5'h0_1;
			end
		end
	end
	assign pin_eff = flt_out;

	// ======================================================
	// Low-voltage and stop acknowledge sources
	logic        lvd_active;  // Detector powered in this mode
	logic        lvd_trip;    // Low-voltage reset request
	logic [10:0] sack_cnt;    // Slow ticks since stop request
	logic        sack_err;    // Stop ack timeout pulse

	// Detector runs only in run, high-speed run, wait and stop [R12]
	assign lvd_active = (mode_in == rsf_pkg::RSF_MODE_RUN) || (mode_in == rsf_pkg::RSF_MODE_HSRUN)
	                 || (mode_in == rsf_pkg::RSF_MODE_WAIT) || (mode_in == rsf_pkg::RSF_MODE_STOP);
	// Trip only while enabled [R9]
	assign lvd_trip   = lvd_active && lowvolt_reset_enable_in && sup_s;

	// Count slow ticks while the stop request waits for acknowledge [R19]
	always_ff @(posedge clock_in) begin
		if (rst_in || !stop_req_in || stop_ack_in || chip_reset_out) begin
			sack_cnt <= 11'h000;
			sack_err <= 1'b0;
		end else begin
			sack_err <= 1'b0;
			if (low_power_osc_clock_in) begin
				if (sack_cnt == 11'(SACK_LIMIT - 1)) begin
					sack_err <= 1'b1;
					sack_cnt <= 11'h000;
				end else begin
					sack_cnt <= sack_cnt + 11'h001;
				end
			end
		end
	end

	// ======================================================
	// Reset cause flags
	logic por_seen;  // First cycle after power-on release
	logic any_src;   // Some system source requests reset

	// Flags hold the last cause; cleared when a fresh reset starts [R7]
	assign any_src = lvd_trip || !pin_eff || sack_err || other_reset_req_in;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			reset_cause_flags_out <= `RSF_CAUSE_RST;
			por_seen              <= 1'b1;
		end else begin
			por_seen <= 1'b0;
			if (por_seen) begin
				reset_cause_flags_out[`RSF_BIT_POR] <= 1'b1;  // [R8]
				reset_cause_flags_out[`RSF_BIT_LVD] <= 1'b1;  // [R8] [R11]
			// Capture only while running, so the entry edge does not recapture
			end else if ((any_src || jtag_reset_req_in) && !chip_reset_out
			             && state == rsf_pkg::RSF_ST_RUN) begin
				reset_cause_flags_out                <= `RSF_CAUSE_RST;
				reset_cause_flags_out[`RSF_BIT_LVD]  <= lvd_trip;            // [R11]
				reset_cause_flags_out[`RSF_BIT_PIN]  <= !pin_eff;            // [R6] [R20]
				reset_cause_flags_out[`RSF_BIT_SACK] <= sack_err;            // [R19]
				reset_cause_flags_out[`RSF_BIT_OTHER] <= other_reset_req_in;
				reset_cause_flags_out[`RSF_BIT_JTAG] <= jtag_reset_req_in;   // [R17]
			end
		end
	end

	// ======================================================
	// Reset sequencer
	rsf_pkg::rsf_state_e state;
	logic [7:0]          hold_cnt;  // Pin drive cycles

	// Hold, wait for pin and supply release, then run [R10] [R18]
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state    <= rsf_pkg::RSF_ST_HOLD;
			hold_cnt <= 8'h00;
		end else begin
			case (state)
				rsf_pkg::RSF_ST_HOLD: begin
					if (hold_cnt != 8'(HOLD_CYC - 1)) begin
						hold_cnt <= hold_cnt + 8'h01;
					end else if (flash_init_done_in && !lvd_trip) begin
						state <= rsf_pkg::RSF_ST_WAIT;
					end
				end
				rsf_pkg::RSF_ST_WAIT: begin
					// Pin still held outside delays the release
					if (pin_eff && !lvd_trip) begin
						state <= rsf_pkg::RSF_ST_RUN;
					end
				end
				rsf_pkg::RSF_ST_RUN: begin
					// Debug reset does not restart the system [R17]
					if (any_src) begin
						state    <= rsf_pkg::RSF_ST_HOLD;
						hold_cnt <= 8'h00;
					end
				end
				default: begin
					state <= rsf_pkg::RSF_ST_HOLD;
				end
			endcase
		end
	end

	// ======================================================
	// Registered outputs
	// Pin drive, chip reset, default pin and supply states [R14] [R15] [R16]
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			reset_pin_out             <= 1'b0;
			reset_pin_oe_out          <= 1'b1;
			chip_reset_out            <= 1'b1;
			periph_enable_out         <= 1'b0;
			regulator_full_out        <= 1'b1;
			internal_clock_sel_out    <= 1'b1;
			test_pin_pull_up_out      <= 4'b0011;  // TDI, TMS; TDO, nTRST none
			tck_pull_down_out         <= 1'b1;
			lowvolt_threshold_out     <= 2'b00;
			lowvolt_detect_enable_out <= 1'b1;
		end else begin
			// Open drain: drive low only in the hold phase [R6] [R18]
			reset_pin_out             <= 1'b0;
			reset_pin_oe_out          <= (state == rsf_pkg::RSF_ST_HOLD);
			chip_reset_out            <= (state != rsf_pkg::RSF_ST_RUN);
			regulator_full_out        <= (state != rsf_pkg::RSF_ST_RUN) || regulator_full_out;
			internal_clock_sel_out    <= 1'b1;
			periph_enable_out         <= 1'b0;
			test_pin_pull_up_out      <= 4'b0011;
			tck_pull_down_out         <= 1'b1;
			lowvolt_threshold_out     <= lowvolt_threshold_select_in;  // [R9]
			lowvolt_detect_enable_out <= lvd_active;                   // [R12]
		end
	end

	// Boot fetch addresses on release [R13] [R17]
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			boot_out <= '0;
		end else begin
			boot_out.valid    <= (state == rsf_pkg::RSF_ST_RUN);
			boot_out.sp_addr  <= `RSF_SP_OFFSET;
			boot_out.pc_addr  <= `RSF_PC_OFFSET;
			boot_out.link_reg <= `RSF_LR_RESET;
		end
	end

	// ======================================================
	// Checks
	AST_PIN_HOLD: assert property (@(posedge clock_in) disable iff (rst_in) // [R18]
		$rose(state == rsf_pkg::RSF_ST_HOLD) |-> ##1 reset_pin_oe_out [*8])
		else $error("reset pin released too early");
	AST_LVD_HOLD: assert property (@(posedge clock_in) disable iff (rst_in) // [R10]
		lvd_trip |=> state != rsf_pkg::RSF_ST_RUN)
		else $error("ran while supply low");
	AST_LVD_GATE: assert property (@(posedge clock_in) disable iff (rst_in) // [R9]
		(state == rsf_pkg::RSF_ST_RUN && !lowvolt_reset_enable_in && !any_src) |=> state == rsf_pkg::RSF_ST_RUN)
		else $error("reset without source");
	AST_POR_FLAGS: assert property (@(posedge clock_in) disable iff (rst_in) // [R8]
		$fell(por_seen) |-> reset_cause_flags_out[`RSF_BIT_POR] && reset_cause_flags_out[`RSF_BIT_LVD])
		else $error("power-on flags missing");
	AST_BYPASS: assert property (@(posedge clock_in) disable iff (rst_in) // [R4]
		deep_stop |=> flt_out == $past(pin_s))
		else $error("filter not bypassed");
	AST_PIN_FLAG: assert property (@(posedge clock_in) disable iff (rst_in) // [R20]
		$rose(reset_cause_flags_out[`RSF_BIT_PIN]) |-> !$past(flt_out))
		else $error("pin flag without filtered pin");
	AST_SLOW_FILT: assert property (@(posedge clock_in) disable iff (rst_in) // [R5]
		(use_slow && !deep_stop && !low_power_osc_clock_in) |=> $stable(flt_out))
		else $error("slow filter moved without tick");
	AST_LVD_MODE: assert property (@(posedge clock_in) disable iff (rst_in) // [R12]
		(mode_in == rsf_pkg::RSF_MODE_VLP) |=> !lowvolt_detect_enable_out)
		else $error("detector on in low power mode");
	AST_BOOT: assert property (@(posedge clock_in) disable iff (rst_in) // [R13]
		boot_out.valid |-> boot_out.pc_addr == `RSF_PC_OFFSET && boot_out.link_reg == `RSF_LR_RESET)
		else $error("boot values wrong");
endmodule // rsf_top
`default_nettype wire
